// ### core/fovl_pkg.sv
// Constants and register map of the FIFO overflow latch bank
package fovl_pkg;
	localparam int FOVL_WORD_W = 32;
	localparam int FOVL_WORDS = 5;
	localparam int FOVL_CHANNELS = 160;
	localparam int FOVL_ADDR_W = 12;
	localparam int FOVL_IDX_W = 10;
	localparam int FOVL_IDX_LSB = 2;
	// Register indices; byte address is four times the index
	localparam logic [9:0] FOVL_IDX_IRQ_CTRL = 10'h0d8;
	localparam logic [9:0] FOVL_IDX_FIFO_SUM = 10'h0d9;
	localparam logic [9:0] FOVL_IDX_OVF_CH1_32 = 10'h0da;
	localparam logic [9:0] FOVL_IDX_OVF_CH33_64 = 10'h0db;
	localparam logic [9:0] FOVL_IDX_OVF_CH65_96 = 10'h0dc;
	localparam logic [9:0] FOVL_IDX_OVF_CH97_128 = 10'h0dd;
	localparam logic [9:0] FOVL_IDX_OVF_CH129_160 = 10'h0de;
	localparam logic [9:0] FOVL_IDX_OVF [FOVL_WORDS] = '{FOVL_IDX_OVF_CH1_32, FOVL_IDX_OVF_CH33_64,
		FOVL_IDX_OVF_CH65_96, FOVL_IDX_OVF_CH97_128, FOVL_IDX_OVF_CH129_160};
	// Interrupt control fields
	localparam int FOVL_CTRL_GLOBAL_EN_BIT = 31;
	localparam int FOVL_CTRL_OVF_EN_BIT = 25;
	localparam int FOVL_CTRL_ANY_OVF_BIT = 9;
	localparam int FOVL_CTRL_EN_STRB_LANE = 3;
	localparam logic FOVL_CTRL_GLOBAL_EN_RST = 1'b1;
	localparam logic FOVL_CTRL_OVF_EN_RST = 1'b1;
	// Summary field: one bit per flag word from this bit upward
	localparam int FOVL_SUM_OVF_LSB = 0;
	localparam logic [31:0] FOVL_FLAGS_RST = 32'h0000_0000;
	localparam logic [31:0] FOVL_RD_ZERO = 32'h0000_0000;
endpackage

// ### core/fovl_ifc.sv
// Carriers between the overflow bank top and its word and bus-front modules
`timescale 1ns/1ps
`default_nettype none
interface fovl_word_ifc;
	logic [31:0] set;
	logic clr;
	logic [31:0] flags;
	logic any;
	modport owner (input set, input clr, output flags, output any);
	modport user (output set, output clr, input flags, input any);
endinterface

interface fovl_bus_ifc;
	logic sel_ctrl;
	logic sel_sum;
	logic [4:0] sel_ovf;
	logic wr_stb;
	logic rd_ld;
	modport front (output sel_ctrl, output sel_sum, output sel_ovf, output wr_stb, output rd_ld);
	modport core (input sel_ctrl, input sel_sum, input sel_ovf, input wr_stb, input rd_ld);
endinterface
`default_nettype wire

// ### core/fovl_flag_word.sv
// One 32-bit word of sticky overflow flags with clear on write
`timescale 1ns/1ps
`default_nettype none
module fovl_flag_word
	import fovl_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Flag word carrier
	fovl_word_ifc.owner w
);
	logic [31:0] flags;
	logic [31:0] next_flags;

	// RULE_12: a set in the clearing cycle wins
	assign next_flags = (flags & ~{32{w.clr}}) | w.set;

	// RULE_01: flags hold until cleared
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			flags <= FOVL_FLAGS_RST;
		end else begin
			flags <= next_flags;
		end
	end

	assign w.flags = flags;
	// RULE_12: word summary is the OR of its flags
	assign w.any = |flags;
endmodule
`default_nettype wire

// ### core/fovl_apb_front.sv
// APB slave front end: address decode, ready and error answer
`timescale 1ns/1ps
`default_nettype none
module fovl_apb_front
	import fovl_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// APB request
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	// APB answer
	output logic pready,
	output logic pslverr,
	// Decoded access to the register core
	fovl_bus_ifc.front bus
);
	logic [9:0] idx;
	logic [4:0] hit_ovf;
	logic hit_ctrl;
	logic hit_sum;
	logic mapped;
	logic setup;
	logic complete;
	logic next_pready;
	logic next_pslverr;

	assign idx = paddr[FOVL_ADDR_W-1:FOVL_IDX_LSB];
	assign hit_ctrl = (idx == FOVL_IDX_IRQ_CTRL);
	assign hit_sum = (idx == FOVL_IDX_FIFO_SUM);

	genvar i;
	generate
		for (i = 0; i < FOVL_WORDS; i++) begin : g_dec
			assign hit_ovf[i] = (idx == FOVL_IDX_OVF[i]);
		end
	endgenerate

	assign mapped = hit_ctrl | hit_sum | (|hit_ovf);
	assign setup = psel & ~penable;
	assign complete = psel & penable & pready;
	// One wait-free access phase: ready follows every setup cycle
	assign next_pready = setup & ~pready;
	assign next_pslverr = setup & ~pready & ~mapped;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= next_pready;
			pslverr <= next_pslverr;
		end
	end

	assign bus.sel_ctrl = hit_ctrl;
	assign bus.sel_sum = hit_sum;
	assign bus.sel_ovf = hit_ovf;
	assign bus.wr_stb = complete & pwrite & mapped;
	assign bus.rd_ld = setup & ~pwrite;
endmodule
`default_nettype wire

// ### core/fovl_bank.sv
// Latched overflow flag bank for 160 input FIFOs with APB access
// Operation
// RULE_01: One sticky overflow flag per input FIFO
// RULE_02: Any write clears the written flag register
// RULE_03: Word one holds FIFOs 1 to 32
// RULE_04: Word two holds FIFOs 33 to 64
// RULE_05: Word three holds FIFOs 65 to 96
// RULE_06: Word four holds FIFOs 97 to 128
// RULE_07: Word five holds FIFOs 129 to 160
// RULE_08: Summary bit 0 flags channels 1-32
// RULE_09: Summary bits 1-4 flag remaining groups
// RULE_10: Control bit 9 reports any overflow
// RULE_11: Interrupt needs bits 25 and 31 set
// RULE_12: Summary is OR; set beats clear
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module fovl_bank
	import fovl_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Overflow events from the input FIFOs, bit n for FIFO n+1
	input wire logic [159:0] fifo_ovf_event,
	// Status toward interrupt logic
	output logic [4:0] ovf_summary,
	output logic any_fifo_ovf_latched,
	output logic ovf_irq
);
	fovl_bus_ifc bus ();

	logic [31:0] ovf_acc [FOVL_WORDS+1];
	logic [4:0] word_any;
	logic any_now;
	logic fifo_ovf_irq_enable;
	logic global_irq_enable;
	logic ctrl_wr;
	logic [31:0] ctrl_rd;
	logic [31:0] sum_rd;
	logic [31:0] ovf_rd;
	logic [31:0] rd_mux;
	logic [31:0] next_prdata;

	fovl_apb_front u_front (
		.clk(clk),
		.rst_n(rst_n),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pready(pready),
		.pslverr(pslverr),
		.bus(bus)
	);

	genvar i;
	generate
		for (i = 0; i < FOVL_WORDS; i++) begin : g_word
			fovl_word_ifc wif ();
			// RULE_03: word 0 takes FIFOs 1-32, FIFO 1 at bit 0
			// RULE_04: word 1 takes FIFOs 33-64
			// RULE_05: word 2 takes FIFOs 65-96
			// RULE_06: word 3 takes FIFOs 97-128
			// RULE_07: word 4 takes FIFOs 129-160
			assign wif.set = fifo_ovf_event[i*FOVL_WORD_W +: FOVL_WORD_W];
			// RULE_02: any write value clears this word
			assign wif.clr = bus.wr_stb & bus.sel_ovf[i];
			// Decode is one-hot, so an OR chain picks the addressed word
			assign ovf_acc[i+1] = ovf_acc[i] | (bus.sel_ovf[i] ? wif.flags : FOVL_RD_ZERO);
			assign word_any[i] = wif.any;
			fovl_flag_word u_word (
				.clk(clk),
				.rst_n(rst_n),
				.w(wif)
			);
		end
	endgenerate

	// RULE_10: global latched status is any flag set
	assign any_now = |word_any;
	assign ctrl_wr = bus.wr_stb & bus.sel_ctrl & pstrb[FOVL_CTRL_EN_STRB_LANE];

	assign ctrl_rd = (32'(global_irq_enable) << FOVL_CTRL_GLOBAL_EN_BIT)
		| (32'(fifo_ovf_irq_enable) << FOVL_CTRL_OVF_EN_BIT)
		| (32'(any_fifo_ovf_latched) << FOVL_CTRL_ANY_OVF_BIT);

	assign sum_rd = 32'(ovf_summary) << FOVL_SUM_OVF_LSB;

	assign ovf_acc[0] = FOVL_RD_ZERO;
	assign ovf_rd = ovf_acc[FOVL_WORDS];

	// Unmapped reads return zero
	assign rd_mux = bus.sel_ctrl ? ctrl_rd : (bus.sel_sum ? sum_rd : ovf_rd);
	assign next_prdata = bus.rd_ld ? rd_mux : prdata;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			prdata <= FOVL_RD_ZERO;
		end else begin
			prdata <= next_prdata;
		end
	end

	// Enables live in byte lane 3 of the control register
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			global_irq_enable <= FOVL_CTRL_GLOBAL_EN_RST;
			fifo_ovf_irq_enable <= FOVL_CTRL_OVF_EN_RST;
		end else if (ctrl_wr) begin
			global_irq_enable <= pwdata[FOVL_CTRL_GLOBAL_EN_BIT];
			fifo_ovf_irq_enable <= pwdata[FOVL_CTRL_OVF_EN_BIT];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ovf_summary <= 5'h00;
			any_fifo_ovf_latched <= 1'b0;
			ovf_irq <= 1'b0;
		end else begin
			// RULE_08: bit 0 summarises FIFOs 1-32
			// RULE_09: bits 1-4 summarise the other words
			ovf_summary <= word_any;
			// RULE_10: any-overflow latched status
			any_fifo_ovf_latched <= any_now;
			// RULE_11: both enables gate the interrupt
			ovf_irq <= any_now & fifo_ovf_irq_enable & global_irq_enable;
		end
	end
endmodule
`default_nettype wire

// ### testbench/fovl_bank_sva.sv
// Port-level assertions for the overflow latch bank
`timescale 1ns/1ps
`default_nettype none
module fovl_bank_sva
	import fovl_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Bus
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic pready,
	// Status
	input wire logic [159:0] fifo_ovf_event,
	input wire logic [4:0] ovf_summary,
	input wire logic any_fifo_ovf_latched,
	input wire logic ovf_irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	logic ctrl_wr_seen;
	logic model_glb_en;
	logic model_ovf_en;
	assign ctrl_wr_seen = psel && penable && pready && pwrite && paddr == {FOVL_IDX_IRQ_CTRL, 2'b00}
		&& pstrb[FOVL_CTRL_EN_STRB_LANE];
	// Enable bits as software last wrote them
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			model_glb_en <= FOVL_CTRL_GLOBAL_EN_RST;
			model_ovf_en <= FOVL_CTRL_OVF_EN_RST;
		end else if (ctrl_wr_seen) begin
			model_glb_en <= pwdata[FOVL_CTRL_GLOBAL_EN_BIT];
			model_ovf_en <= pwdata[FOVL_CTRL_OVF_EN_BIT];
		end
	end
	sequence s_wr(a);
		psel && penable && pready && pwrite && paddr == a;
	endsequence
	property p_sum0;
		|fifo_ovf_event[31:0] |-> ##2 ovf_summary[0];
	endproperty
	a_sum0: assert property (p_sum0) else $error("summary bit 0 missed");
	property p_sum4;
		|fifo_ovf_event[159:128] |-> ##2 ovf_summary[4];
	endproperty
	a_sum4: assert property (p_sum4) else $error("summary bit 4 missed");
	property p_any;
		|fifo_ovf_event |-> ##2 any_fifo_ovf_latched;
	endproperty
	a_any: assert property (p_any) else $error("any overflow missed");
	property p_irq;
		ovf_irq == (any_fifo_ovf_latched && $past(model_glb_en && model_ovf_en));
	endproperty
	a_irq: assert property (p_irq) else $error("irq without overflow");
	property p_hold;
		$fell(ovf_summary[0]) |-> $past(psel && penable && pready && pwrite && paddr == 12'h368, 2);
	endproperty
	a_hold: assert property (p_hold) else $error("flag lost without write");
	property p_clr;
		s_wr(12'h36c) ##0 fifo_ovf_event[63:32] == 32'h0 |-> ##2 !ovf_summary[1];
	endproperty
	a_clr: assert property (p_clr) else $error("write did not clear");
	property p_win;
		s_wr(12'h368) ##0 fifo_ovf_event[0] |-> ##2 ovf_summary[0] [*2];
	endproperty
	a_win: assert property (p_win) else $error("clear beat set");
	property p_rdy;
		psel && !penable |=> pready;
	endproperty
	a_rdy: assert property (p_rdy) else $error("no ready in access");
endmodule

bind fovl_bank fovl_bank_sva u_sva (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
	.fifo_ovf_event(fifo_ovf_event),
	.ovf_summary(ovf_summary), .any_fifo_ovf_latched(any_fifo_ovf_latched), .ovf_irq(ovf_irq));
`default_nettype wire

// ### testbench/fovl_bank_test.sv
// Self-checking bench for the overflow latch bank
`timescale 1ns/1ps
`default_nettype none
module fovl_bank_test;
	logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [3:0] pstrb = 4'hf;
	logic [159:0] fifo_ovf_event = 160'h0;
	logic pready, pslverr, any_fifo_ovf_latched, ovf_irq, er;
	logic [4:0] ovf_summary;
	int err_total = 0, n_tests = 0;
	always #5 clk = ~clk;
	fovl_bank u_dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .fifo_ovf_event(fifo_ovf_event), .ovf_summary(ovf_summary),
		.any_fifo_ovf_latched(any_fifo_ovf_latched), .ovf_irq(ovf_irq));
	task chk(input logic [31:0] seen, exp, input string what);
		n_tests++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH %s exp %h seen %h", what, exp, seen);
		end
	endtask
	// Events given here are raised in the access cycle
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [159:0] ev);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		fifo_ovf_event <= ev;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		fifo_ovf_event <= 160'h0;
	endtask
	task pulse(input logic [159:0] ev);
		@(posedge clk);
		fifo_ovf_event <= ev;
		@(posedge clk);
		fifo_ovf_event <= 160'h0;
	endtask
	task t_reset;
		for (int k = 0; k < 5; k++) begin
			apb(1'b0, 12'h368 + 12'(4 * k), 32'h0, 160'h0);
			chk(rd, 32'h0, "flag word reset");
		end
		apb(1'b0, 12'h360, 32'h0, 160'h0);
		chk(rd, 32'h8200_0000, "ctrl reset");
		chk(32'(er), 32'h0, "mapped error");
	endtask
	task t_map;
		for (int k = 0; k < 5; k++) begin
			pulse(160'h8000_0001 << (32 * k));
			apb(1'b0, 12'h368 + 12'(4 * k), 32'h0, 160'h0);
			chk(rd, 32'h8000_0001, "flag word");
			chk(32'(ovf_summary), 32'h1 << k, "summary");
			apb(1'b0, 12'h364, 32'h0, 160'h0);
			chk(rd, 32'h1 << k, "summary register");
			apb(1'b1, 12'h368 + 12'(4 * k), 32'h1234_5678, 160'h0);
			apb(1'b0, 12'h368 + 12'(4 * k), 32'h0, 160'h0);
			chk(rd, 32'h0, "cleared word");
		end
	endtask
	task t_win;
		pulse(160'h80);
		apb(1'b1, 12'h368, 32'hffff_ffff, 160'h1);
		apb(1'b0, 12'h368, 32'h0, 160'h0);
		chk(rd, 32'h1, "set over clear");
		apb(1'b1, 12'h368, 32'h0, 160'h0);
	endtask
	task t_irq;
		pulse(160'h1 << 159);
		apb(1'b0, 12'h360, 32'h0, 160'h0);
		chk(rd, 32'h8200_0200, "ctrl any");
		chk(32'(ovf_irq), 32'h1, "irq on");
		pstrb <= 4'h7;
		apb(1'b1, 12'h360, 32'h0, 160'h0);
		pstrb <= 4'hf;
		apb(1'b0, 12'h360, 32'h0, 160'h0);
		chk(rd, 32'h8200_0200, "ctrl lane 3 off");
		chk(32'(ovf_irq), 32'h1, "irq kept");
		apb(1'b1, 12'h360, 32'h8000_0000, 160'h0);
		apb(1'b0, 12'h360, 32'h0, 160'h0);
		chk(32'(ovf_irq), 32'h0, "irq local off");
		apb(1'b1, 12'h360, 32'h0200_0000, 160'h0);
		apb(1'b0, 12'h360, 32'h0, 160'h0);
		chk(32'(ovf_irq), 32'h0, "irq global off");
		apb(1'b1, 12'h378, 32'h0, 160'h0);
		apb(1'b1, 12'h360, 32'h8200_0000, 160'h0);
		chk(32'(any_fifo_ovf_latched), 32'h0, "any cleared");
	endtask
	task t_err;
		apb(1'b0, 12'h3fc, 32'h0, 160'h0);
		chk(rd, 32'h0, "unmapped data");
		chk(32'(er), 32'h1, "unmapped error");
		apb(1'b1, 12'h364, 32'hffff_ffff, 160'h0);
		apb(1'b0, 12'h364, 32'h0, 160'h0);
		chk(rd, 32'h0, "summary read only");
	endtask
	task final_report;
		$display("checks %0d errors %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		t_reset;
		t_map;
		t_win;
		t_irq;
		t_err;
		final_report;
	end
	initial begin
		#200000;
		err_total++;
		final_report;
	end
endmodule
`default_nettype wire
